// [rtl/coherence_ctrl_pkg.sv]
package coherence_ctrl_pkg;

  // build limits of the cluster
  localparam int MAX_CORES = 6;
  localparam int MAX_VP    = 4;
  localparam int MAX_IO_COHERENCE_UNIT  = 2;
  localparam int IDX_W     = 5;
  localparam int SLOTS     = MAX_CORES * MAX_VP;

  // offsets inside an 8 KB sub-block
  localparam logic [12:0] OFF_SYS_CONFIG  = 13'h0000;
  localparam logic [12:0] OFF_WIN_BASE    = 13'h0008;
  localparam logic [12:0] OFF_REMOTE_SEL  = 13'h0018;
  localparam logic [12:0] OFF_LOCAL_DATA  = 13'h0020;
  localparam logic [12:0] OFF_CUSTOM_BASE = 13'h0060;
  localparam logic [12:0] OFF_IRQ_BASE    = 13'h0080;
  localparam logic [12:0] OFF_POWER_BASE  = 13'h0088;
  localparam logic [12:0] OFF_IOC_BASE    = 13'h0100;
  localparam logic [12:0] OFF_WRITE_PERM  = 13'h0120;

  // base field low bits, all fields end at bit 47
  localparam int WIN_LSB    = 15;
  localparam int CUSTOM_LSB = 16;
  localparam int IRQ_LSB    = 17;
  localparam int POWER_LSB  = 15;
  localparam int IOC_LSB    = 15;
  localparam int ENABLE_BIT = 0;

  // reset values
  localparam logic [63:0] WIN_BASE_RST = 64'h0000_1fbf_8000;
  localparam logic [63:0] PERM_RST     = 64'h0000_0000_0003_003f;
  localparam logic [63:0] PERM_MASK    = 64'h0000_0000_0003_003f;

  // system configuration field positions
  localparam int CFG_CORES_LSB = 0;
  localparam int CFG_IO_COHERENCE_UNIT_LSB  = 8;
  localparam int CFG_MMIO_LSB  = 16;
  localparam int CFG_ITU_BIT   = 31;
  localparam int CFG_DBU_BIT   = 40;
  localparam int CFG_NOC_LSB   = 41;

  // remote-core select fields
  localparam int          SEL_VP_LSB    = 0;
  localparam int          SEL_CORE_LSB  = 8;
  localparam int          SEL_BLOCK_LSB = 24;
  localparam logic [63:0] SEL_MASK      = 64'h0000_0000_0300_3f07;

  // requestor id of the first io coherence unit
  localparam logic [4:0] IO_COHERENCE_UNIT_ID_BASE = 5'h10;

  typedef enum logic [1:0] {
    SUB_GLOBAL = 2'b00,
    SUB_LOCAL  = 2'b01,
    SUB_OTHER  = 2'b10,
    SUB_DEBUG  = 2'b11
  } sub_block_t;

  typedef enum logic [2:0] {
    ROUTE_NONE   = 3'b000,
    ROUTE_WINDOW = 3'b001,
    ROUTE_CUSTOM = 3'b010,
    ROUTE_IRQ    = 3'b011,
    ROUTE_POWER  = 3'b100,
    ROUTE_IOC    = 3'b101
  } route_t;

  typedef struct packed {
    logic        write;
    logic [4:0]  src;
    logic [2:0]  vp;
    logic [47:0] addr;
    logic [63:0] wdata;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    route_t      route;
    logic        wr_allow;
  } resp_t;

  typedef struct packed {
    logic [63:0]                 win_base;
    logic [63:0]                 custom_base;
    logic [63:0]                 irq_base;
    logic [63:0]                 power_base;
    logic [63:0]                 ioc_base;
    logic [63:0]                 perm;
    logic [SLOTS-1:0][63:0]      remote_sel;
    resp_t                       resp;
    logic                        use_mem;
  } ctrl_state_t;

endpackage

// [rtl/coherence_ctrl_register_bank.sv]
`timescale 1ns/1ps
// Overview of operation
// (R1) redirect loaded first; core-other follows selected core
// (R2) 0x2000-0x3FFF reaches requesting core's local registers
// (R3) 0x4000-0x5FFF reaches selected core, same offsets
// (R4) one copy per core and per vp
// (R5) remote-core select sits at local offset 0x18
// (R6) without relocation option window fixed at default
// (R7) configuration register read-only build constants
// (R8) cores 7:0, io units 11:8, mmio 19:16
// (R9) itu bit 31, debug bit 40, noc 43:41
// (R10) window base bits 47:15, 32 KB aligned
// (R11) custom base 47:16, decoded only when enabled
// (R12) irq controller base 47:17, enable gated
// (R13) power controller base 47:15, enable gated
// (R14) io coherence base 47:15, enable gated
// (R15) all read; writes need requestor grant
// (R16) grant bits 5:0 cores, 17:16 io units
// (R17) ungranted writes silently dropped
// (R18) grant field resets to 0x3003f
// (R19) grant also gates power controller writes
// (R20) window split into four 8 KB sub-blocks
// (R21) select bits 13:8 core, 2:0 vp
// (R22) select bits 25:24 pick redirected block
// (R23) unimplemented offsets read zero, ignore writes
// (R24) out-of-range selected core reads zero
module coherence_ctrl_register_bank
  import coherence_ctrl_pkg::*;
#(
  parameter int          NUM_CORES   = 6,
  parameter int          NUM_VP      = 4,
  parameter int          NUM_IO_COHERENCE_UNIT    = 2,
  parameter int          NUM_MMIO    = 4,
  parameter bit          RELOCATABLE = 1'b1,
  parameter bit          ITU_PRESENT = 1'b1,
  parameter bit          DBU_PRESENT = 1'b1,
  parameter logic [2:0]  NOC_TYPE    = 3'h0
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        req_valid,
  input  wire coherence_ctrl_pkg::req_t    req,
  output logic                             resp_valid,
  output logic [63:0]                      resp_rdata,
  output coherence_ctrl_pkg::route_t       resp_route,
  output logic                             resp_wr_allow
);
  import coherence_ctrl_pkg::*;

  // build-time constants, never writable
  localparam logic [63:0] CFG_VALUE =
    (64'(NUM_CORES) << CFG_CORES_LSB) | (64'(NUM_IO_COHERENCE_UNIT) << CFG_IO_COHERENCE_UNIT_LSB) |
    (64'(NUM_MMIO) << CFG_MMIO_LSB) | (64'(ITU_PRESENT) << CFG_ITU_BIT) |
    (64'(DBU_PRESENT) << CFG_DBU_BIT) | (64'(NOC_TYPE) << CFG_NOC_LSB); // R7 R8 R9

  // mask of bits [47:lsb]
  function automatic logic [63:0] field_mask(input int lsb);
    field_mask = ~((64'h1 << lsb) - 64'h1) & 64'h0000_ffff_ffff_ffff;
  endfunction

  // address falls in the aligned region held by base
  function automatic logic region_match(input logic [47:0] a, input logic [63:0] b, input int lsb);
    region_match = (({16'h0, a} ^ b) & field_mask(lsb)) == 64'h0;
  endfunction

  // flat slot of one core and one vp
  function automatic logic [IDX_W-1:0] slot_of(input logic [5:0] core, input logic [2:0] vp);
    slot_of = IDX_W'(32'(core) * MAX_VP + 32'(vp));
  endfunction

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  logic              is_core;
  logic              is_io_coherence_unit;
  logic              grant;
  logic              wr_ok;
  logic              own_ok;
  logic [IDX_W-1:0]  own_idx;
  logic [63:0]       own_sel;
  logic [5:0]        sel_core;
  logic [2:0]        sel_vp;
  logic [1:0]        sel_block;
  logic              in_win;
  sub_block_t        sub;
  logic [12:0]       roff;
  logic              to_global;
  logic              to_local;
  logic              tgt_ok;
  logic [IDX_W-1:0]  tgt_idx;
  logic              glob_mapped;
  logic              custom_hit;
  logic              irq_hit;
  logic              power_hit;
  logic              ioc_hit;
  logic              mem_we;
  logic [63:0]       mem_rdata;

  // who is asking and may it write
  always_comb begin
    is_core = 32'(req.src) < NUM_CORES;
    is_io_coherence_unit = (req.src >= IO_COHERENCE_UNIT_ID_BASE) && (32'(req.src) < 32'(IO_COHERENCE_UNIT_ID_BASE) + NUM_IO_COHERENCE_UNIT);
    grant   = (is_core || is_io_coherence_unit) && s_r.perm[req.src]; // R15 R16
    wr_ok   = req_valid && req.write && grant; // R17
    own_ok  = is_core && (32'(req.vp) < NUM_VP);
    own_idx = slot_of(6'(req.src), req.vp); // R4
    own_sel = own_ok ? s_r.remote_sel[own_idx] : 64'h0;
    sel_core  = own_sel[SEL_CORE_LSB +: 6]; // R21
    sel_vp    = own_sel[SEL_VP_LSB +: 3];
    sel_block = own_sel[SEL_BLOCK_LSB +: 2]; // R22
  end

  // window and sub-block decode
  always_comb begin
    in_win    = region_match(req.addr, s_r.win_base, WIN_LSB); // R10
    sub       = sub_block_t'(req.addr[14:13]); // R20
    roff      = req.addr[12:0];
    to_global = 1'b0;
    to_local  = 1'b0;
    tgt_ok    = 1'b0;
    tgt_idx   = own_idx;
    case (sub)
      SUB_GLOBAL: begin
        to_global = 1'b1;
      end
      SUB_LOCAL: begin
        to_local = 1'b1; // R2
        tgt_ok   = own_ok;
      end
      SUB_OTHER: begin
        // an io unit has no select register, so it reaches nothing here
        to_local  = sel_block == 2'h0; // R1 R3
        tgt_ok    = own_ok && (32'(sel_core) < NUM_CORES) && (32'(sel_vp) < NUM_VP); // R24
        to_global = tgt_ok && (sel_block == 2'h1); // a missing core sees no global block either
        tgt_idx   = slot_of(sel_core, sel_vp);
      end
      default: begin
        to_global = 1'b0; // debug registers live elsewhere and read zero
      end
    endcase
  end

  // outside-window regions, decoded only while enabled
  always_comb begin
    custom_hit = s_r.custom_base[ENABLE_BIT] && region_match(req.addr, s_r.custom_base, CUSTOM_LSB); // R11
    irq_hit    = s_r.irq_base[ENABLE_BIT] && region_match(req.addr, s_r.irq_base, IRQ_LSB); // R12
    power_hit  = s_r.power_base[ENABLE_BIT] && region_match(req.addr, s_r.power_base, POWER_LSB); // R13
    ioc_hit    = s_r.ioc_base[ENABLE_BIT] && region_match(req.addr, s_r.ioc_base, IOC_LSB); // R14
  end

  // register reads, writes and the answer
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    glob_mapped = 1'b0;
    s_nxt.resp.valid    = req_valid;
    s_nxt.resp.data     = 64'h0;
    s_nxt.resp.route    = ROUTE_NONE;
    s_nxt.resp.wr_allow = 1'b0;
    s_nxt.use_mem       = 1'b0;
    if (req_valid && in_win) begin
      s_nxt.resp.route    = ROUTE_WINDOW;
      s_nxt.resp.wr_allow = req.write && grant;
      if (to_global) begin
        glob_mapped = 1'b1;
        case (roff)
          OFF_SYS_CONFIG: begin
            s_nxt.resp.data = CFG_VALUE; // R7
          end
          OFF_WIN_BASE: begin
            s_nxt.resp.data = s_r.win_base;
            if (wr_ok && RELOCATABLE) begin
              s_nxt.win_base = req.wdata & field_mask(WIN_LSB); // R6 R10
            end
          end
          OFF_CUSTOM_BASE: begin
            s_nxt.resp.data = s_r.custom_base;
            if (wr_ok) begin
              s_nxt.custom_base = req.wdata & (field_mask(CUSTOM_LSB) | 64'h1); // R11
            end
          end
          OFF_IRQ_BASE: begin
            s_nxt.resp.data = s_r.irq_base;
            if (wr_ok) begin
              s_nxt.irq_base = req.wdata & (field_mask(IRQ_LSB) | 64'h1); // R12
            end
          end
          OFF_POWER_BASE: begin
            s_nxt.resp.data = s_r.power_base;
            if (wr_ok) begin
              s_nxt.power_base = req.wdata & (field_mask(POWER_LSB) | 64'h1); // R13
            end
          end
          OFF_IOC_BASE: begin
            s_nxt.resp.data = s_r.ioc_base;
            if (wr_ok) begin
              s_nxt.ioc_base = req.wdata & (field_mask(IOC_LSB) | 64'h1); // R14
            end
          end
          OFF_WRITE_PERM: begin
            s_nxt.resp.data = s_r.perm;
            if (wr_ok) begin
              s_nxt.perm = req.wdata & PERM_MASK; // R16
            end
          end
          default: begin
            glob_mapped = 1'b0; // R23
          end
        endcase
      end else if (to_local && tgt_ok) begin
        case (roff)
          OFF_REMOTE_SEL: begin
            s_nxt.resp.data = s_r.remote_sel[tgt_idx]; // R5
            if (wr_ok) begin
              s_nxt.remote_sel[tgt_idx] = req.wdata & SEL_MASK; // R21 R22
            end
          end
          OFF_LOCAL_DATA: begin
            s_nxt.use_mem = !req.write; // R4
            mem_we        = wr_ok;
          end
          default: begin
            s_nxt.resp.data = 64'h0; // R23
          end
        endcase
      end
    end else if (req_valid) begin
      // writes to the power block obey the same grant
      s_nxt.resp.wr_allow = req.write && grant; // R19
      if (power_hit) begin
        s_nxt.resp.route = ROUTE_POWER;
      end else if (irq_hit) begin
        s_nxt.resp.route = ROUTE_IRQ;
      end else if (custom_hit) begin
        s_nxt.resp.route = ROUTE_CUSTOM;
      end else if (ioc_hit) begin
        s_nxt.resp.route = ROUTE_IOC;
      end else begin
        s_nxt.resp.route = ROUTE_NONE;
      end
    end
  end

  // reset: window at default, all requestors granted, regions off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r          <= '0;
      s_r.win_base <= WIN_BASE_RST; // R6
      s_r.perm     <= PERM_RST; // R18
    end else begin
      s_r <= s_nxt;
    end
  end

  // per-vp words kept in a small memory, read a cycle later
  per_vp_store #(
    .DEPTH (SLOTS),
    .WIDTH (64),
    .AW    (IDX_W)
  ) u_store (
    .mclk  (mclk),
    .rst   (rst),
    .we    (mem_we),
    .idx   (tgt_idx),
    .wdata (req.wdata),
    .rdata (mem_rdata)
  );

  assign resp_valid    = s_r.resp.valid;
  assign resp_rdata    = s_r.use_mem ? mem_rdata : s_r.resp.data;
  assign resp_route    = s_r.resp.route;
  assign resp_wr_allow = s_r.resp.wr_allow;

  // checks on the bank's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // a config write, then a config read after at most one idle cycle
  sequence cfg_write_s;
    req_valid && req.write && in_win && to_global && (roff == OFF_SYS_CONFIG);
  endsequence

  sequence cfg_read_s;
    req_valid && !req.write && in_win && to_global && (roff == OFF_SYS_CONFIG);
  endsequence

  sequence blocked_write_s;
    req_valid && req.write && !grant && in_win;
  endsequence

  sequence sel_write_s;
    wr_ok && in_win && to_local && tgt_ok && (roff == OFF_REMOTE_SEL);
  endsequence

  // covers both builds: relocatable takes the field, fixed keeps the default
  sequence base_write_s;
    wr_ok && in_win && to_global && (roff == OFF_WIN_BASE);
  endsequence

  // a core-other write that names a missing core or vp
  sequence bad_other_write_s;
    req_valid && req.write && in_win && (sub == SUB_OTHER) && !tgt_ok;
  endsequence

  // outside the window a region stays dark while its enable is clear
  sequence outside_s;
    req_valid && !in_win;
  endsequence

  a_answer_next_cycle: assert property (req_valid |=> resp_valid ##1 (resp_valid == $past(req_valid))) // R15
    else $error("answer not one cycle after request");
  a_config_constant: assert property (cfg_write_s ##[1:2] cfg_read_s |=> resp_rdata == CFG_VALUE) // R7
    else $error("configuration register changed by a write");
  a_blocked_write_dropped: assert property (blocked_write_s |=> // R17
    $stable(s_r.perm) && $stable(s_r.irq_base) && $stable(s_r.remote_sel) && $stable(s_r.win_base))
    else $error("ungranted write changed a register");
  a_fixed_window_base: assert property (base_write_s |=> // R6 R10
    s_r.win_base == (RELOCATABLE ? ($past(req.wdata) & field_mask(WIN_LSB)) : WIN_BASE_RST))
    else $error("window base write handled wrongly");
  a_select_write_lands: assert property (sel_write_s |=> // R5
    s_r.remote_sel[$past(tgt_idx)] == ($past(req.wdata) & SEL_MASK))
    else $error("select register write lost");
  a_bad_core_zero: assert property (req_valid && !req.write && in_win && sub == SUB_OTHER && !tgt_ok // R24
    |=> resp_rdata == 64'h0)
    else $error("out-of-range core did not read zero");
  a_bad_other_dropped: assert property (bad_other_write_s |-> !mem_we ##1 $stable(s_r.remote_sel)) // R24
    else $error("write through a missing core landed");
  a_unmapped_zero: assert property (req_valid && !req.write && in_win && to_global && !glob_mapped // R23
    |=> resp_rdata == 64'h0)
    else $error("unmapped offset did not read zero");
  a_window_route: assert property (req_valid && in_win |=> resp_route == ROUTE_WINDOW) // R20
    else $error("window request not routed to the bank");
  a_irq_disabled_off: assert property (outside_s ##0 !s_r.irq_base[ENABLE_BIT] |=> // R12
    resp_route != ROUTE_IRQ)
    else $error("disabled irq region decoded");
  a_custom_disabled_off: assert property (outside_s ##0 !s_r.custom_base[ENABLE_BIT] |=> // R11
    resp_route != ROUTE_CUSTOM)
    else $error("disabled custom region decoded");
  a_power_disabled_off: assert property (outside_s ##0 !s_r.power_base[ENABLE_BIT] |=> // R13
    resp_route != ROUTE_POWER)
    else $error("disabled power region decoded");
  a_ioc_disabled_off: assert property (outside_s ##0 !s_r.ioc_base[ENABLE_BIT] |=> // R14
    resp_route != ROUTE_IOC)
    else $error("disabled io coherence region decoded");
  a_power_grant_gate: assert property (req_valid && req.write && power_hit && !in_win // R19
    |=> resp_route == ROUTE_POWER && resp_wr_allow == $past(grant))
    else $error("power write permission wrong");
  a_perm_read_back: assert property (wr_ok && in_win && to_global && roff == OFF_WRITE_PERM // R16
    |=> s_r.perm == ($past(req.wdata) & PERM_MASK))
    else $error("grant register write lost");

endmodule

// [rtl/per_vp_store.sv]
`timescale 1ns/1ps
module per_vp_store #(
  parameter int DEPTH = 24,
  parameter int WIDTH = 64,
  parameter int AW    = 5
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             we,
  input  wire logic [AW-1:0]    idx,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } store_t;

  store_t s_r;
  store_t s_nxt;

  // read returns the old word on a same-cycle write
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = s_r.mem[idx];
    if (we) begin
      s_nxt.mem[idx] = wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rd;
endmodule

// [verification/core_requestor.sv]
`timescale 1ns/1ps
// behavioural core or io unit issuing one register request at a time
module core_requestor (
  input  wire logic                        mclk,
  output logic                             req_valid,
  output coherence_ctrl_pkg::req_t         req,
  input  wire logic                        resp_valid,
  input  wire logic [63:0]                 resp_rdata,
  input  wire coherence_ctrl_pkg::route_t  resp_route,
  input  wire logic                        resp_wr_allow
);
  import coherence_ctrl_pkg::*;

  logic [63:0] rd;
  route_t      rt;
  logic        wa;
  logic        seen;

  // idle until the bench asks for a transfer
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // request held over the taking edge, answer caught just after it
  task automatic xfer(input logic w, input logic [4:0] s, input logic [2:0] v,
                      input logic [47:0] a, input logic [63:0] d);
    @(posedge mclk);
    #1;
    req_valid = 1'b1;
    req       = '{write: w, src: s, vp: v, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    seen      = resp_valid;
    rd        = resp_rdata;
    rt        = resp_route;
    wa        = resp_wr_allow;
    req_valid = 1'b0;
    req       = ~req;  // released lines never keep the last value
  endtask
endmodule

// [verification/test_coherence_ctrl_register_bank.sv]
`timescale 1ns/1ps
module test_coherence_ctrl_register_bank;
  import coherence_ctrl_pkg::*;

  logic        mclk;
  logic        rst;
  logic        req_valid;
  req_t        req;
  logic        resp_valid;
  logic [63:0] resp_rdata;
  route_t      resp_route;
  logic        resp_wr_allow;
  int          miscompares;
  int          samples_checked;
  logic [47:0] wb;
  logic [47:0] a;
  logic [47:0] pa;
  logic [63:0] d;
  logic [63:0] m;
  logic [63:0] pat [24];
  int          t;
  int          tv;
  int          s;
  logic [12:0] roff [4] = '{OFF_CUSTOM_BASE, OFF_IRQ_BASE, OFF_POWER_BASE, OFF_IOC_BASE};
  int          rlsb [4] = '{CUSTOM_LSB, IRQ_LSB, POWER_LSB, IOC_LSB};
  route_t      rrt  [4] = '{ROUTE_CUSTOM, ROUTE_IRQ, ROUTE_POWER, ROUTE_IOC};

  coherence_ctrl_register_bank #(.NUM_CORES(6), .NUM_VP(4), .NUM_IO_COHERENCE_UNIT(2), .NUM_MMIO(4)) u_dut (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_route(resp_route), .resp_wr_allow(resp_wr_allow));

  core_requestor u_req (
    .mclk(mclk), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_route(resp_route), .resp_wr_allow(resp_wr_allow));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // build constants of this instance, packed as the config word
  function automatic logic [63:0] cfg_exp();
    logic [63:0] c;
    c        = '0;
    c[7:0]   = 8'h06;
    c[11:8]  = 4'h2;
    c[19:16] = 4'h4;
    c[31]    = 1'b1;
    c[40]    = 1'b1;
    c[43:41] = 3'h0;
    return c;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every request must be answered one cycle later
  task automatic xa(input logic w, input int src, input int v, input logic [47:0] ad, input logic [63:0] dat);
    u_req.xfer(w, 5'(src), 3'(v), ad, dat);
    chk("resp_valid", 64'h1, {63'h0, u_req.seen});
  endtask

  task automatic acc(input logic w, input int src, input int v, input logic [14:0] off, input logic [63:0] dat);
    xa(w, src, v, wb + {33'h0, off}, dat);
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    miscompares     = 0;
    samples_checked = 0;
    d   = 64'($urandom(32'h0ee91d1d));
    rst = 1'b1;
    wb  = WIN_BASE_RST[47:0];
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    // reset values and the read-only config word
    acc(0, 0, 0, 15'h0000, 0);
    chk("config", cfg_exp(), u_req.rd);
    chk("route", 64'(ROUTE_WINDOW), 64'(u_req.rt));
    acc(1, 0, 0, 15'h0000, '1);
    acc(0, 16, 0, 15'h0000, 0);
    chk("config kept", cfg_exp(), u_req.rd);
    acc(0, 2, 1, 15'(OFF_WRITE_PERM), 0);
    chk("perm reset", PERM_RST, u_req.rd);
    acc(0, 5, 3, 15'(OFF_WIN_BASE), 0);
    chk("window base reset", WIN_BASE_RST, u_req.rd);
    // region bases: masked readback, decode disabled then enabled
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) begin
        m = ((64'h1 << 48) - 64'h1) & ~((64'h1 << rlsb[i]) - 64'h1);
        d = {$urandom, $urandom};
        a = d[47:0] & m[47:0];
        acc(1, i, 0, {2'b00, roff[i]}, (d & ~64'h1) | 64'(k));
        acc(0, 16 + k, 0, {2'b00, roff[i]}, 0);
        chk("base readback", (d & m) | 64'(k), u_req.rd);
        xa(1, i, 0, a, {$urandom, $urandom});
        chk("region route", 64'(k ? rrt[i] : ROUTE_NONE), 64'(u_req.rt));
        if (k == 1) begin
          chk("region write allow", 64'h1, {63'h0, u_req.wa});
        end
        if (i == 2) begin
          pa = a;
        end
      end
    end
    // one word per core and vp through the own local block
    for (int i = 0; i < 24; i++) begin
      pat[i] = {$urandom, $urandom};
      acc(1, i / 4, i % 4, 15'h2000 + 15'(OFF_LOCAL_DATA), pat[i]);
    end
    for (int i = 0; i < 24; i++) begin
      acc(0, i / 4, i % 4, 15'h2000 + 15'(OFF_LOCAL_DATA), 0);
      chk("local word", pat[i], u_req.rd);
    end
    // redirected access, target core 6 is out of range
    for (int n = 0; n < 12; n++) begin
      s  = $urandom % 6;
      tv = $urandom % 4;
      t  = (n == 0) ? 6 : $urandom % 7;
      d  = (64'(t) << 8) | 64'(tv) | 64'hff00_0000_00f0_c0f8;
      acc(1, s, n % 4, 15'h2000 + 15'(OFF_REMOTE_SEL), d);
      acc(0, s, n % 4, 15'h2000 + 15'(OFF_REMOTE_SEL), 0);
      chk("select", d & SEL_MASK, u_req.rd);
      acc(0, s, n % 4, 15'h4000 + 15'(OFF_LOCAL_DATA), 0);
      chk("other read", (t < 6) ? pat[t * 4 + tv] : 64'h0, u_req.rd);
      d = {$urandom, $urandom};
      acc(1, s, n % 4, 15'h4000 + 15'(OFF_LOCAL_DATA), d);
      if (t < 6) begin
        pat[t * 4 + tv] = d;
        acc(0, t, tv, 15'h2000 + 15'(OFF_LOCAL_DATA), 0);
        chk("other write", d, u_req.rd);
      end
    end
    // block select: global, then two blocks that read zero
    for (int b = 1; b < 4; b++) begin
      acc(1, 0, 0, 15'h2000 + 15'(OFF_REMOTE_SEL), 64'(b) << 24);
      acc(0, 0, 0, 15'h4000, 0);
      chk("block select", (b == 1) ? cfg_exp() : 64'h0, u_req.rd);
    end
    // grant of core 3 removed: its writes vanish, reads still work
    acc(1, 0, 0, 15'(OFF_WRITE_PERM), PERM_RST & ~64'h8);
    acc(1, 3, 0, 15'h2000 + 15'(OFF_LOCAL_DATA), ~pat[12]);
    chk("denied allow", 64'h0, {63'h0, u_req.wa});
    acc(0, 3, 0, 15'h2000 + 15'(OFF_LOCAL_DATA), 0);
    chk("denied write", pat[12], u_req.rd);
    xa(1, 3, 0, pa, 64'h5);
    chk("denied power write", 64'h0, {63'h0, u_req.wa});
    xa(1, 7, 0, wb + 48'h2020, 64'h5);
    chk("unknown requestor", 64'h0, {63'h0, u_req.wa});
    acc(1, 17, 0, 15'(OFF_WRITE_PERM), '1);
    chk("io unit allow", 64'h1, {63'h0, u_req.wa});
    acc(0, 3, 0, 15'(OFF_WRITE_PERM), 0);
    chk("perm mask", PERM_MASK, u_req.rd);
    // unmapped global offset, debug block, io unit in local block
    acc(1, 1, 0, 15'h0200, '1);
    acc(0, 1, 0, 15'h0200, 0);
    chk("unmapped", 64'h0, u_req.rd);
    acc(0, 1, 0, 15'h6000, 0);
    chk("debug block", 64'h0, u_req.rd);
    acc(0, 16, 0, 15'h2000 + 15'(OFF_LOCAL_DATA), 0);
    chk("io unit local", 64'h0, u_req.rd);
    // move the window to a fresh 32 KB aligned base
    d = {16'h0, 32'($urandom), 16'h0} & 64'h0000_ffff_ffff_8000;
    acc(1, 2, 0, 15'(OFF_WIN_BASE), d);
    a  = wb;
    wb = d[47:0];
    acc(0, 2, 0, 15'(OFF_WIN_BASE), 0);
    chk("moved base", d, u_req.rd);
    xa(0, 2, 0, a, 0);
    chk("old window", 64'(ROUTE_NONE), 64'(u_req.rt));
    conclude();
  end
endmodule
